// [rtl/utb_pkg.sv]
// Purpose: Shared constants and types for the transmit buffer / CTS change block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   All offsets, register resets and timing counts live here, and the field positions except the channel status ready, count and enable
package utb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TX_BUF    = 8'h00;
  localparam logic [7:0] OFS_IN_CHG    = 8'h04;
  localparam logic [7:0] OFS_AUX_CTRL  = 8'h08;
  localparam logic [7:0] OFS_INT_STAT  = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK  = 8'h10;
  localparam logic [7:0] OFS_CONTROL   = 8'h14;
  localparam logic [7:0] OFS_TX_LEVEL  = 8'h18;
  localparam logic [7:0] OFS_CHAN_STAT = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CHG_FLAG   = 4;
  localparam int BIT_CTS_STATE  = 0;
  localparam int BIT_AUX_EN     = 0;
  localparam int BIT_IS_CTS     = 7;
  localparam int BIT_IS_BREAK   = 2;
  localparam int BIT_IS_RXF     = 1;
  localparam int BIT_IS_TX_READY_FLAG   = 0;
  localparam int BIT_CTL_FIFO   = 0;
  localparam int BIT_CTL_MODEM  = 1;
  localparam int BIT_CTL_FULSEL = 2;
  localparam int BIT_CTL_CMD    = 4;
  localparam int BIT_CTL_BRKRST = 6;
  localparam int BIT_CS_EMPTY   = 1;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_AUX_CTRL = 8'h00;
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [4:0] RST_TX_LEVEL = 5'h08;
  localparam int         FIFO_DEPTH   = 16;
  localparam int         FIFO_AW      = 4;

  // Transmitter commands
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_ENABLE  = 2'h1;
  localparam logic [1:0] CMD_DISABLE = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int FILTER_US     = 25;
  localparam int FILTER_CYCLES = (FILTER_US * (CLK_HZ / 1_000_000));
  localparam int SERIAL_DIV    = 16;
  localparam int CTS_START_CYC = 2 * SERIAL_DIV;
  localparam int BIT_CYCLES    = 16;

  // Transmit shifter state
  typedef enum logic [1:0] {
    UTB_IDLE  = 2'b00,
    UTB_SHIFT = 2'b01
  } utb_shift_state_t;

  // Receiver status group fed in from the receive side
  typedef struct packed {
    logic rx_ready_flag;
    logic rx_fifo_full_flag;
    logic break_edge;
  } utb_rx_status_t;

endpackage

// [rtl/utb_cts_filter.sv]
// Purpose: Synchronise the CTS input and report a filtered level
// Assumes: pclk domain, CTS asynchronous to it
// Notes:   Level only changes after staying stable for the full count
`timescale 1ns/1ps
`default_nettype none
module utb_cts_filter
  import utb_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cts_n_in,
  output logic      level,
  output logic      changed
);

  logic        sync_a;
  logic        sync_b;
  logic [15:0] stable_cnt;

  // Two-stage synchroniser; first flop read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= cts_n_in;
      sync_b <= sync_a;
    end
  end

  // Stability counter; glitches shorter than the interval are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt <= 16'h0000;
      level      <= 1'b1;
      changed    <= 1'b0;
    end else begin
      changed <= 1'b0;
      if (sync_b == level) begin
        stable_cnt <= 16'h0000;
      end else if (stable_cnt == 16'(FILTER_CYCLES - 1)) begin
        stable_cnt <= 16'h0000;
        level      <= sync_b;
        changed    <= 1'b1;
      end else begin
        stable_cnt <= stable_cnt + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/utb_top.sv]
// Purpose: Transmit buffering, CTS change detect and interrupt status for one channel
// Assumes: APB slave on pclk, receive side supplies its status flags
// Notes:   Holding register or FIFO selected by a control bit
`timescale 1ns/1ps
`default_nettype none

module utb_top
  import utb_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  input  wire logic [3:0]     pstrb,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           cts_n,
  input  wire utb_pkg::utb_rx_status_t rx_status,
  output logic                txd,
  output logic                irq_n,
  output logic                dma_req
);
  import utb_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic [7:0]       aux_control;
  logic [7:0]       interrupt_mask;
  logic [7:0]       control;
  logic [4:0]       tx_fifo_threshold;
  logic             tx_enabled;
  logic             tx_ready_flag;
  logic             tx_empty_flag;
  logic [7:0]       hold_reg;
  logic [7:0]       fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW:0] fifo_count;
  logic [FIFO_AW-1:0] rd_ptr;
  logic [FIFO_AW-1:0] wr_ptr;
  logic [2:0]       wr_bytes;
  logic             load_ok;
  logic             buf_write;
  logic             fifo_mode;
  logic             modem_mode;
  logic [7:0]       shift_data;
  logic [3:0]       shift_bit;
  logic [4:0]       bit_tmr;
  utb_shift_state_t shift_state;
  logic             shift_take;
  logic             have_data;
  logic             cts_level;
  logic             cts_chg;
  logic             cts_tracking;
  logic [5:0]       start_cnt;
  logic             cts_state;
  logic             cts_change_flag;
  logic             break_change_flag;
  logic             status_cts;
  logic [7:0]       interrupt_status;
  logic [1:0]       cmd;

  assign fifo_mode  = control[BIT_CTL_FIFO];
  assign modem_mode = control[BIT_CTL_MODEM] & fifo_mode;
  assign cmd        = pwdata[BIT_CTL_CMD +: 2];

  // ----------------------------------------------------------------
  // APB decode: zero wait states, unmapped offsets flag an error
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign addr_ok = (paddr == OFS_TX_BUF) || (paddr == OFS_IN_CHG) ||
                   (paddr == OFS_AUX_CTRL) || (paddr == OFS_INT_STAT) ||
                   (paddr == OFS_INT_MASK) || (paddr == OFS_CONTROL) ||
                   (paddr == OFS_TX_LEVEL) || (paddr == OFS_CHAN_STAT);
  assign pslverr = psel & penable & ~addr_ok;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_control       <= RST_AUX_CTRL;
      interrupt_mask    <= RST_INT_MASK;
      control           <= RST_CONTROL;
      tx_fifo_threshold <= RST_TX_LEVEL;
    end else if (wr_en) begin
      if (paddr == OFS_AUX_CTRL && pstrb[0]) begin
        aux_control <= {7'h00, pwdata[BIT_AUX_EN]};
      end
      if (paddr == OFS_INT_MASK && pstrb[0]) begin
        interrupt_mask <= pwdata[7:0];
      end
      // Command field is a strobe, not stored
      if (paddr == OFS_CONTROL && pstrb[0]) begin
        control <= {5'h00, pwdata[BIT_CTL_FULSEL:0]};
      end
      if (paddr == OFS_TX_LEVEL && pstrb[0]) begin
        tx_fifo_threshold <= pwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer write path
  // ----------------------------------------------------------------
  // Longword writes push one byte per enabled lane
  always_comb begin
    wr_bytes = 3'h0;
    for (int i = 0; i < 4; i++) begin
      wr_bytes = wr_bytes + {2'h0, pstrb[i]};
    end
  end

  assign buf_write = wr_en && (paddr == OFS_TX_BUF);
  // Holding path: ready and enabled; FIFO path: room, and enabled unless modem
  assign load_ok = fifo_mode ?
    ((tx_enabled | modem_mode) &&
     ({2'h0, wr_bytes} <= (6'(FIFO_DEPTH) - {1'b0, fifo_count}))) :
    (tx_enabled && tx_ready_flag);

  assign have_data  = fifo_mode ? (fifo_count != '0) : ~tx_ready_flag;
  assign shift_take = (shift_state == UTB_IDLE) && have_data && tx_enabled;

  // Holding register store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 8'h00;
    end else if (buf_write && load_ok && !fifo_mode) begin
      hold_reg <= pwdata[7:0];
    end
  end

  // FIFO storage, one generate per entry
  for (genvar e = 0; e < FIFO_DEPTH; e++) begin : g_fifo
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fifo_mem[e] <= 8'h00;
      end else if (buf_write && load_ok && fifo_mode) begin
        for (int b = 0; b < 4; b++) begin
          if (pstrb[b] && (FIFO_AW'(e) == FIFO_AW'(wr_ptr + FIFO_AW'(b)))) begin
            fifo_mem[e] <= pwdata[8*b +: 8];
          end
        end
      end
    end
  end

  // FIFO pointers; byte lane b stored at wr_ptr plus b, pointer advances by the enabled lane count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fifo_count <= '0;
    end else if (fifo_mode) begin
      if (buf_write && load_ok) begin
        wr_ptr <= wr_ptr + FIFO_AW'(wr_bytes);
      end
      if (shift_take) begin
        rd_ptr <= rd_ptr + FIFO_AW'(1);
      end
      fifo_count <= fifo_count + ((buf_write && load_ok) ? (FIFO_AW+1)'(wr_bytes) : '0)
                    - (shift_take ? (FIFO_AW+1)'(1) : '0);
    end
  end

  // ----------------------------------------------------------------
  // Transmitter enable and ready/empty flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enabled    <= 1'b0;
      tx_ready_flag <= 1'b0;
      tx_empty_flag <= 1'b0;
    end else begin
      if (fifo_mode) begin
        // Ready tracks FIFO fill against threshold
        tx_ready_flag <= (tx_enabled | modem_mode) &&
                         (fifo_count <= {1'b0, tx_fifo_threshold[FIFO_AW-1:0]});
      end else if (buf_write && load_ok) begin
        tx_ready_flag <= 1'b0;
      end else if (shift_take) begin
        tx_ready_flag <= 1'b1;
      end
      if (shift_take || (buf_write && load_ok)) begin
        tx_empty_flag <= 1'b0;
      end else if (shift_state == UTB_IDLE && !have_data && tx_enabled) begin
        tx_empty_flag <= 1'b1;
      end
      if (wr_en && paddr == OFS_CONTROL && pstrb[0]) begin
        if (cmd == CMD_ENABLE && !tx_enabled) begin
          tx_enabled <= 1'b1;
          if (!fifo_mode) begin
            tx_ready_flag <= 1'b1;
            tx_empty_flag <= 1'b1;
          end
        end else if (cmd == CMD_DISABLE && tx_enabled) begin
          tx_enabled    <= 1'b0;
          tx_empty_flag <= 1'b0;
          if (!modem_mode) begin
            tx_ready_flag <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter: start, eight data bits, stop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_state <= UTB_IDLE;
      shift_data  <= 8'h00;
      shift_bit   <= 4'h0;
      bit_tmr     <= 5'h00;
      txd         <= 1'b1;
    end else begin
      unique case (shift_state)
        UTB_IDLE: begin
          txd <= 1'b1;
          if (shift_take) begin
            shift_data  <= fifo_mode ? fifo_mem[rd_ptr] : hold_reg;
            shift_state <= UTB_SHIFT;
            shift_bit   <= 4'h0;
            bit_tmr     <= 5'h00;
            txd         <= 1'b0;
          end
        end
        UTB_SHIFT: begin
          if (bit_tmr == 5'(BIT_CYCLES - 1)) begin
            bit_tmr   <= 5'h00;
            shift_bit <= shift_bit + 4'h1;
            if (shift_bit == 4'h9) begin
              shift_state <= UTB_IDLE;
            end else if (shift_bit == 4'h8) begin
              txd <= 1'b1;
            end else begin
              txd        <= shift_data[0];
              shift_data <= {1'b0, shift_data[7:1]};
            end
          end else begin
            bit_tmr <= bit_tmr + 5'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // CTS change detection
  // ----------------------------------------------------------------
  utb_cts_filter u_cts_filter (
    .pclk     (pclk),
    .presetn  (presetn),
    .cts_n_in (cts_n),
    .level    (cts_level),
    .changed  (cts_chg)
  );

  // Tracking begins two serial clocks after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt    <= 6'h00;
      cts_tracking <= 1'b0;
    end else if (!cts_tracking) begin
      start_cnt <= start_cnt + 6'h01;
      if (start_cnt == 6'(CTS_START_CYC - 1)) begin
        cts_tracking <= 1'b1;
      end
    end
  end

  // State bit is the pin level: 0 asserted, 1 negated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_state <= 1'b1;
    end else if (cts_tracking && !modem_mode) begin
      cts_state <= cts_level;
    end
  end

  // Change flag: set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_change_flag <= 1'b0;
      status_cts      <= 1'b0;
    end else begin
      if (!modem_mode && ((cts_tracking && cts_chg) ||
          (!cts_tracking && start_cnt == 6'(CTS_START_CYC - 1) && !cts_level))) begin
        cts_change_flag <= 1'b1;
        status_cts      <= status_cts | aux_control[BIT_AUX_EN];
      end else if (rd_en && paddr == OFS_IN_CHG) begin
        cts_change_flag <= 1'b0;
        status_cts      <= 1'b0;
      end
    end
  end

  // Break change: sticky until reset-break command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_change_flag <= 1'b0;
    end else if (rx_status.break_edge) begin
      break_change_flag <= 1'b1;
    end else if (wr_en && paddr == OFS_CONTROL && pstrb[0] && pwdata[BIT_CTL_BRKRST]) begin
      break_change_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and request
  // ----------------------------------------------------------------
  always_comb begin
    interrupt_status               = 8'h00;
    interrupt_status[BIT_IS_CTS]   = status_cts & ~modem_mode;
    interrupt_status[BIT_IS_BREAK] = break_change_flag;
    interrupt_status[BIT_IS_RXF]   = control[BIT_CTL_FULSEL] ?
                                     rx_status.rx_fifo_full_flag :
                                     rx_status.rx_ready_flag;
    interrupt_status[BIT_IS_TX_READY_FLAG] = tx_ready_flag;
  end

  // Registered request so the pin is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n   <= 1'b1;
      dma_req <= 1'b0;
    end else begin
      irq_n   <= ~|(interrupt_status & interrupt_mask);
      dma_req <= control[BIT_CTL_FULSEL] & rx_status.rx_fifo_full_flag &
                 interrupt_mask[BIT_IS_RXF];
    end
  end

  // ----------------------------------------------------------------
  // Read mux; write-only buffer reads zero
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_IN_CHG:    prdata = {27'h0, cts_change_flag, 3'h0, cts_state};
      OFS_AUX_CTRL:  prdata = {24'h0, aux_control};
      OFS_INT_STAT:  prdata = {24'h0, interrupt_status};
      OFS_INT_MASK:  prdata = {24'h0, interrupt_mask};
      OFS_CONTROL:   prdata = {24'h0, control};
      OFS_TX_LEVEL:  prdata = {27'h0, tx_fifo_threshold};
      OFS_CHAN_STAT: prdata = {23'h0, tx_enabled, 1'b0, fifo_count, tx_empty_flag,
                               tx_ready_flag};
      default:       prdata = 32'h0000_0000;
    endcase
  end

endmodule
`default_nettype wire

// [testbench/utb_serial_peer.sv]
// Purpose: Remote serial peer: drives CTS, decodes transmit frames
// Assumes: 16 pclk per bit, start bit low, data LSB first
// Notes:   Stop bit is reported with the data so framing is checked
`timescale 1ns/1ps
`default_nettype none
module utb_serial_peer (
  input  wire logic       pclk,
  input  wire logic       txd,
  input  wire logic       cts_hold_n,
  output logic            cts_n,
  output logic [8:0]      rx_word,
  output logic            rx_vld
);
  logic [8:0] w;
  // CTS is a level the peer always drives, as the bench commands
  assign cts_n = cts_hold_n;
  // Mid-bit sampling; a start shorter than half a bit is a glitch
  initial begin
    rx_vld = 1'b0;
    rx_word = 9'h000;
    forever begin
      @(negedge txd);
      repeat (8) @(posedge pclk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 9; i++) begin
          repeat (16) @(posedge pclk);
          w[i] = txd;
        end
        rx_word <= w;
        rx_vld <= 1'b1;
        @(posedge pclk);
        rx_vld <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/utb_top_assertions.sv]
// Purpose: Port-level checks on interrupt, DMA and CTS reporting
// Assumes: One pclk domain, mask and control written with all byte lanes
// Notes:   Mask and full-select are shadowed from APB writes
`timescale 1ns/1ps
`default_nettype none
module utb_checker
  import utb_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   cts_n,
  input wire utb_pkg::utb_rx_status_t rx_status,
  input wire logic                   txd,
  input wire logic                   irq_n,
  input wire logic                   dma_req
);
  logic        acc_wr, rd_chg, rd_stat, fsel, brk;
  logic        cts_q, seen, long_q;
  logic [7:0]  msk;
  logic [11:0] stab;
  assign acc_wr  = psel && penable && pwrite;
  assign rd_chg  = psel && penable && !pwrite && paddr == OFS_IN_CHG;
  assign rd_stat = psel && penable && !pwrite && paddr == OFS_INT_STAT;
  // Shadows; partial-lane writes would fool them, bench does them only to the transmit buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk <= RST_INT_MASK;
      fsel <= 1'b0;
      brk <= 1'b0;
    end else begin
      if (acc_wr && paddr == OFS_INT_MASK) msk <= pwdata[7:0];
      if (acc_wr && paddr == OFS_CONTROL) fsel <= pwdata[BIT_CTL_FULSEL];
      if (acc_wr && paddr == OFS_CONTROL && pwdata[BIT_CTL_BRKRST]) brk <= 1'b0;
      else if (rd_stat && prdata[BIT_IS_BREAK]) brk <= 1'b1;
    end
  end
  // Age of the CTS level; the margin covers sync and filter latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_q <= 1'b1;
      stab <= 12'h000;
      seen <= 1'b0;
      long_q <= 1'b0;
    end else begin
      cts_q <= cts_n;
      if (cts_n != cts_q) begin
        stab <= 12'h000;
        seen <= 1'b0;
        long_q <= stab > 12'd1100;
      end else begin
        if (stab != 12'hFFF) stab <= stab + 12'd1;
        if (rd_chg && stab > 12'd1100) seen <= 1'b1;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_nor: assert property (rd_stat |=> irq_n == !(|($past(prdata[7:0]) & msk)))
    else $error("irq_n not the NOR of unmasked status");
  a_irq_masked: assert property (msk == 8'h00 && $past(msk) == 8'h00 |-> irq_n)
    else $error("irq_n low with all status masked");
  a_dma_req: assert property (dma_req == $past(fsel && rx_status.rx_fifo_full_flag && msk[1]))
    else $error("dma_req does not follow full fifo");
  a_rx_bit1: assert property (rd_stat && $stable(rx_status) |-> prdata[BIT_IS_RXF] ==
    (fsel ? rx_status.rx_fifo_full_flag : rx_status.rx_ready_flag))
    else $error("status bit1 wrong source");
  a_break_hold: assert property (rd_stat && brk |-> prdata[BIT_IS_BREAK])
    else $error("break change flag lost before command");
  a_cts_state: assert property (rd_chg && stab > 12'd1100 |-> prdata[BIT_CTS_STATE] == cts_n)
    else $error("cts state bit wrong");
  a_chg_clear: assert property (rd_chg && seen |-> !prdata[BIT_CHG_FLAG])
    else $error("change flag not cleared by read");
  a_cts_filter: assert property (rd_chg && stab < 12'd900 && long_q |->
    prdata[BIT_CTS_STATE] != cts_n)
    else $error("cts state followed a short pulse");
endmodule
bind utb_top utb_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .cts_n, .rx_status, .txd, .irq_n, .dma_req
);
`default_nettype wire

// [testbench/utb_top_bench.sv]
// Purpose: Self-checking bench for transmit buffering, CTS and status
// Assumes: Zero-wait APB slave, peer decodes the serial line
// Notes:   Expected reads and bytes are queued, a watcher compares
`timescale 1ns/1ps
`default_nettype none
module utb_top_bench;
  import utb_pkg::*;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic           cts_n, cts_hold_n, txd, irq_n, dma_req, rx_vld;
  logic [7:0]     paddr;
  logic [3:0]     pstrb;
  logic [31:0]    pwdata, prdata, d;
  logic [31:0]    seed = 32'h000042AD;
  logic [8:0]     rx_word;
  utb_rx_status_t rx_status;
  logic [32:0]    exp_q[$], msk_q[$];
  logic [8:0]     byte_q[$];
  int             miscompares, samples_checked;
  utb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cts_n, .rx_status, .txd, .irq_n, .dma_req);
  utb_serial_peer u_peer (.pclk, .txd, .cts_hold_n, .cts_n, .rx_word, .rx_vld);
  // ----------------------------------------------------------------
  // Reporting and compares
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bad(input string s);
    miscompares++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic check_read(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
    samples_checked++;
    if ((g & m) !== (e & m)) bad("read value");
  endtask
  task automatic check_byte(input logic [8:0] g, input logic [8:0] e);
    samples_checked++;
    if (g !== e) bad("serial frame");
  endtask
  task automatic flag(input logic g, input logic e);
    samples_checked++;
    if (g !== e) bad("output level");
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // ----------------------------------------------------------------
  // APB master; request held until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv,
                     input logic [3:0] s, input logic [32:0] e, input logic [32:0] m);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    pstrb <= s;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad("no pready");
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    apb(1'b1, a, dv, 4'hF, 33'h0, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 32'h0, 4'hF, {25'h0, e}, {1'b1, 24'h0, m});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Bounded wait for the peer to report every queued byte
  task automatic drain();
    int n = 0;
    while (byte_q.size() > 0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      bad("bytes never sent");
      finish_test();
    end
  endtask
  // Watcher: oldest note is taken whenever a result shows up
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && msk_q.size() > 0)
      check_read({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
    if (rx_vld === 1'b1) begin
      if (byte_q.size() == 0) bad("byte not written");
      else check_byte(rx_word, byte_q.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    bad("run timeout");
    finish_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    cts_hold_n = 1'b1;
    rx_status = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_AUX_CTRL, RST_AUX_CTRL, 8'hFF);
    rd(OFS_INT_STAT, 8'h00, 8'hFF);
    apb(1'b0, 8'h20, 32'h0, 4'hF, 33'h100000000, 33'h100000000);
    wr(OFS_TX_BUF, 32'h5A);
    wr(OFS_CONTROL, 32'h10);
    rd(OFS_INT_STAT, 8'h01, 8'h01);
    rd(OFS_CHAN_STAT, 8'h03, 8'h03);
    for (int k = 0; k < 2; k++) begin
      d = xs();
      wr(OFS_TX_BUF, d);
      byte_q.push_back({1'b1, d[7:0]});
    end
    rd(OFS_INT_STAT, 8'h00, 8'h01);
    wr(OFS_TX_BUF, xs());
    drain();
    rd(OFS_INT_STAT, 8'h01, 8'h01);
    wr(OFS_INT_MASK, 32'h01);
    rd(OFS_INT_STAT, 8'h01, 8'hFF);
    flag(irq_n, 1'b0);
    wr(OFS_INT_MASK, 32'h00);
    idle(2);
    flag(irq_n, 1'b1);
    wr(OFS_AUX_CTRL, 32'h01);
    cts_hold_n <= 1'b0;
    idle(1100);
    rd(OFS_INT_STAT, 8'h80, 8'h80);
    rd(OFS_IN_CHG, 8'h10, 8'h11);
    rd(OFS_IN_CHG, 8'h00, 8'h11);
    rd(OFS_INT_STAT, 8'h00, 8'h80);
    wr(OFS_AUX_CTRL, 32'h00);
    cts_hold_n <= 1'b1;
    idle(1100);
    rd(OFS_INT_STAT, 8'h00, 8'h80);
    rd(OFS_IN_CHG, 8'h11, 8'h11);
    cts_hold_n <= 1'b0;
    idle(200);
    rd(OFS_IN_CHG, 8'h01, 8'h11);
    cts_hold_n <= 1'b1;
    idle(1100);
    rd(OFS_IN_CHG, 8'h01, 8'h11);
    wr(OFS_CONTROL, 32'h01);
    wr(OFS_TX_LEVEL, 32'h02);
    d = xs();
    wr(OFS_TX_BUF, d);
    for (int k = 0; k < 4; k++) byte_q.push_back({1'b1, d[8*k +: 8]});
    rd(OFS_INT_STAT, 8'h00, 8'h01);
    drain();
    rd(OFS_INT_STAT, 8'h01, 8'h01);
    wr(OFS_CONTROL, 32'h23);
    d = xs();
    apb(1'b1, OFS_TX_BUF, d, 4'h1, 33'h0, 33'h0);
    byte_q.push_back({1'b1, d[7:0]});
    cts_hold_n <= 1'b0;
    idle(1050);
    rd(OFS_IN_CHG, 8'h01, 8'h11);
    wr(OFS_CONTROL, 32'h13);
    drain();
    wr(OFS_CONTROL, 32'h21);
    apb(1'b1, OFS_TX_BUF, xs(), 4'h1, 33'h0, 33'h0);
    wr(OFS_CONTROL, 32'h11);
    idle(400);
    rx_status <= 3'b101;
    idle(1);
    rx_status <= 3'b100;
    rd(OFS_INT_STAT, 8'h06, 8'h06);
    rd(OFS_INT_STAT, 8'h04, 8'h04);
    wr(OFS_CONTROL, 32'h41);
    rd(OFS_INT_STAT, 8'h02, 8'h06);
    wr(OFS_CONTROL, 32'h05);
    wr(OFS_INT_MASK, 32'h02);
    rx_status <= 3'b010;
    rd(OFS_INT_STAT, 8'h02, 8'h02);
    flag(dma_req, 1'b1);
    // Mid-run reset with CTS held asserted
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    idle(1100);
    rd(OFS_IN_CHG, 8'h10, 8'h11);
    finish_test();
  end
endmodule
`default_nettype wire
